// File: hdl/nbc_client.sv
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module nbc_client #(
  parameter int MS_CYCLES = nbc_pkg::CYC_PER_MS
) (
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          resetn,
  // Boot sources
  input  wire logic                          bootStrap,
  input  wire logic                          softReset,
  input  wire logic [47:0]                   ownAddr,
  input  wire logic [31:0]                   configWord,
  input  wire logic [15:0]                   idRandom,
  // Received message
  input  wire logic                          rxValid,
  input  wire logic [1:0]                    rxKind,
  input  wire logic [47:0]                   rxSrcAddr,
  input  wire logic [47:0]                   rxServerAddr,
  input  wire logic [15:0]                   rxTimeout,
  input  wire logic [nbc_pkg::MID_BITS-1:0]  rxMsgId,
  input  wire logic                          rxRunCode,
  // Command executor
  output logic                               cmdStart,
  input  wire logic                          cmdDone,
  input  wire logic [7:0]                    cmdResult,
  // Transmitted message
  output logic                               txValid,
  input  wire logic                          txReady,
  output logic [1:0]                         txKind,
  output logic                               txIsReply,
  output logic [47:0]                        txDstAddr,
  output logic [7:0]                         txVersion,
  output logic [7:0]                         txBufCount,
  output logic [15:0]                        txBufLen,
  output logic [47:0]                        txOwnAddr,
  output logic [nbc_pkg::MID_BITS-1:0]       txMsgId,
  output logic [15:0]                        txTimeout,
  output logic [31:0]                        txConfig,
  output logic [7:0]                         txResult,
  // Status
  output logic [7:0]                         statusLed,
  output logic                               runCode,
  // AXI4-Lite slave
  input  wire logic [7:0]                    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [7:0]                    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready
);
  import nbc_pkg::*;

  nbc_state_t state;
  logic [4:0]   findCnt;
  logic [4:0]   selCnt;
  logic [15:0]  curTimeout;
  logic [15:0]  msLeft;
  logic [31:0]  cycCnt;
  logic         timeoutHit;
  logic [47:0]  serverAddr;
  logic [SID_BITS-1:0] sessionId;
  logic [31:0]  msgSerial;
  logic [31:0]  ctrlReg;
  logic         strapSeen;
  logic         bootTrigger;
  logic         cmdBusy;
  logic         cmdIsRun;
  logic         txPend;
  logic         reloadTimer;
  logic         awTaken;
  logic         wTaken;
  logic [7:0]   awAddr;
  logic [31:0]  wData;
  logic [3:0]   wStrb;

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] dat,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return r;
  endfunction

  wire rxFromServer = rxValid && (rxSrcAddr == serverAddr);
  wire txBusy       = txValid || txPend;
  wire hostBoot     = ctrlReg[0];

  // Boot trigger: strap level sampled on every second cycle while idle, or host request
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      strapSeen <= 1'b0;
    end else begin
      strapSeen <= (state == NBC_IDLE) && !bootTrigger && !strapSeen;
    end
  end

  assign bootTrigger = (state == NBC_IDLE) && ((strapSeen && bootStrap) || hostBoot);

  // Millisecond timeout timer
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cycCnt <= '0;
      msLeft <= '0;
    end else if (reloadTimer) begin
      cycCnt <= '0;
      msLeft <= curTimeout;
    end else if (txBusy || cmdBusy) begin
      cycCnt <= '0;
    end else if (msLeft != 16'h0000) begin
      if (cycCnt == 32'(MS_CYCLES - 1)) begin
        cycCnt <= '0;
        msLeft <= msLeft - 16'h0001;
      end else begin
        cycCnt <= cycCnt + 32'h00000001;
      end
    end
  end

  // A reload pending this cycle makes the old count stale, so no timeout then
  assign timeoutHit = (msLeft == 16'h0001) && (cycCnt == 32'(MS_CYCLES - 1)) && !txBusy && !cmdBusy
                      && !reloadTimer;

  // Main state machine
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn || softReset) begin
      state       <= NBC_IDLE;
      findCnt     <= '0;
      selCnt      <= '0;
      curTimeout  <= TIMEOUT_DFLT;
      serverAddr  <= BCAST_ADDR;
      sessionId   <= '0;
      txPend      <= 1'b0;
      txKind      <= MSG_FIND;
      txIsReply   <= 1'b0;
      txDstAddr   <= BCAST_ADDR;
      txMsgId     <= '0;
      txTimeout   <= TIMEOUT_DFLT;
      txResult    <= LED_OK;
      msgSerial   <= '0;
      cmdStart    <= 1'b0;
      cmdBusy     <= 1'b0;
      cmdIsRun    <= 1'b0;
      reloadTimer <= 1'b0;
      statusLed   <= LED_OK;
      runCode     <= 1'b0;
    end else begin
      cmdStart    <= 1'b0;
      reloadTimer <= 1'b0;
      txPend      <= 1'b0;
      case (state)
        NBC_IDLE: begin
          if (bootTrigger) begin
            findCnt    <= 5'h01;
            serverAddr <= BCAST_ADDR;
            txKind     <= MSG_FIND;
            txIsReply  <= 1'b0;
            txDstAddr  <= BCAST_ADDR;
            txMsgId    <= {idRandom, 80'h0, msgSerial};
            txTimeout  <= curTimeout;
            msgSerial  <= msgSerial + 32'h00000001;
            txPend     <= 1'b1;
            reloadTimer <= 1'b1;
            state      <= NBC_FINDW;
          end
        end
        NBC_FINDW: begin
          if (rxValid && !txBusy && rxKind == MSG_FIND && rxMsgId == txMsgId) begin
            serverAddr <= rxServerAddr;
            curTimeout <= rxTimeout;
            selCnt     <= 5'h01;
            txKind     <= MSG_SELECT;
            txDstAddr  <= rxServerAddr;
            txMsgId    <= {idRandom, 80'h0, msgSerial};
            txTimeout  <= rxTimeout;
            msgSerial  <= msgSerial + 32'h00000001;
            txPend     <= 1'b1;
            reloadTimer <= 1'b1;
            state      <= NBC_SELW;
          end else if (timeoutHit) begin
            if (findCnt < RETRY_LIMIT) begin
              findCnt   <= findCnt + 5'h01;
              txMsgId   <= {idRandom, 80'h0, msgSerial};
              msgSerial <= msgSerial + 32'h00000001;
              txPend    <= 1'b1;
              reloadTimer <= 1'b1;
            end else begin
              statusLed <= LED_ABORT;
              state     <= NBC_ABORT;
            end
          end
        end
        NBC_SELW: begin
          if (rxFromServer && !txBusy && rxKind == MSG_SELECT && rxMsgId == txMsgId) begin
            sessionId  <= rxMsgId[MID_BITS-1 -: SID_BITS];
            curTimeout <= rxTimeout;
            reloadTimer <= 1'b1;
            state      <= NBC_CMDW;
          end else if (timeoutHit) begin
            reloadTimer <= 1'b1;
            txMsgId    <= {idRandom, 80'h0, msgSerial};
            msgSerial  <= msgSerial + 32'h00000001;
            if (selCnt < RETRY_LIMIT) begin
              selCnt <= selCnt + 5'h01;
              txPend <= 1'b1;
            end else if (findCnt < RETRY_LIMIT) begin
              findCnt    <= findCnt + 5'h01;
              serverAddr <= BCAST_ADDR;
              txKind     <= MSG_FIND;
              txDstAddr  <= BCAST_ADDR;
              txPend     <= 1'b1;
              state      <= NBC_FINDW;
            end else begin
              statusLed <= LED_ABORT;
              state     <= NBC_ABORT;
            end
          end
        end
        NBC_CMDW: begin
          if (cmdBusy) begin
            if (cmdDone) begin
              cmdBusy   <= 1'b0;
              txKind    <= MSG_CMD;
              txIsReply <= 1'b1;
              txResult  <= cmdResult;
              txPend    <= 1'b1;
              reloadTimer <= 1'b1;
              if (cmdIsRun) begin
                runCode <= 1'b1;
                state   <= NBC_RUN;
              end
            end
          end else if (rxFromServer && !txBusy && rxKind == MSG_CMD
                       && rxMsgId[MID_BITS-1 -: SID_BITS] == sessionId) begin
            txDstAddr <= serverAddr;
            txMsgId   <= rxMsgId;
            cmdIsRun  <= rxRunCode;
            cmdBusy   <= 1'b1;
            cmdStart  <= 1'b1;
          end else if (timeoutHit) begin
            reloadTimer <= 1'b1;
            txIsReply <= 1'b0;
            if (findCnt < RETRY_LIMIT) begin
              findCnt    <= findCnt + 5'h01;
              serverAddr <= BCAST_ADDR;
              txKind     <= MSG_FIND;
              txDstAddr  <= BCAST_ADDR;
              txMsgId    <= {idRandom, 80'h0, msgSerial};
              txTimeout  <= curTimeout;
              msgSerial  <= msgSerial + 32'h00000001;
              txPend     <= 1'b1;
              state      <= NBC_FINDW;
            end else begin
              statusLed <= LED_ABORT;
              state     <= NBC_ABORT;
            end
          end
        end
        NBC_RUN: state <= NBC_RUN;
        NBC_ABORT: state <= NBC_ABORT;
        default: state <= NBC_IDLE;
      endcase
    end
  end

  // Transmit handshake
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      txValid <= 1'b0;
    end else if (txPend) begin
      txValid <= 1'b1;
    end else if (txReady) begin
      txValid <= 1'b0;
    end
  end

  // Fixed request fields
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      txVersion  <= '0;
      txBufCount <= '0;
      txBufLen   <= '0;
      txOwnAddr  <= '0;
      txConfig   <= '0;
    end else begin
      txVersion  <= PROTO_VERSION;
      txBufCount <= RX_BUF_COUNT;
      txBufLen   <= RX_BUF_LEN;
      txOwnAddr  <= ownAddr;
      txConfig   <= configWord;
    end
  end

  // AXI4-Lite write channel
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      awTaken <= 1'b0;
      wTaken  <= 1'b0;
      awAddr  <= '0;
      wData   <= '0;
      wStrb   <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AXI_OKAY;
      ctrlReg <= CTRL_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awTaken <= 1'b1;
        awAddr  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wTaken <= 1'b1;
        wData  <= s_axi_wdata;
        wStrb  <= s_axi_wstrb;
      end
      if (state != NBC_IDLE) begin
        ctrlReg[0] <= 1'b0;
      end
      if (awTaken && wTaken && !s_axi_bvalid) begin
        awTaken <= 1'b0;
        wTaken  <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr == REG_CTRL) ? AXI_OKAY : AXI_SLVERR;
        if (awAddr == REG_CTRL) begin
          ctrlReg <= mergeBytes(ctrlReg, wData, wStrb);
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !awTaken && !s_axi_bvalid;
  assign s_axi_wready  = !wTaken && !s_axi_bvalid;

  // AXI4-Lite read channel
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= AXI_OKAY;
      case (s_axi_araddr)
        REG_CTRL:     s_axi_rdata <= ctrlReg;
        REG_STATUS:   s_axi_rdata <= {16'h0, statusLed, 2'h0, state};
        REG_COUNTERS: s_axi_rdata <= {19'h0, selCnt, 3'h0, findCnt};
        REG_TIMEOUT:  s_axi_rdata <= {16'h0, curTimeout};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;
endmodule // nbc_client
`default_nettype wire

// File: hdl/nbc_pkg.sv
`default_nettype none
package nbc_pkg;
  localparam int          CLK_MHZ          = 100;
  localparam int          TIMEOUT_MS_DFLT  = 3000;
  localparam int          CYC_PER_MS       = CLK_MHZ * 1000;
  localparam logic [15:0] TIMEOUT_DFLT     = 16'(TIMEOUT_MS_DFLT);
  localparam logic [4:0]  RETRY_LIMIT      = 5'h10;
  localparam int          SID_BITS         = 96;
  localparam int          MID_BITS         = 128;
  localparam logic [7:0]  PROTO_VERSION    = 8'h01;
  localparam logic [7:0]  RX_BUF_COUNT     = 8'h01;
  localparam logic [15:0] RX_BUF_LEN       = 16'h0600;
  localparam logic [47:0] BCAST_ADDR       = 48'hffffffffffff;

  // AXI4-Lite register offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_COUNTERS = 8'h08;
  localparam logic [7:0] REG_TIMEOUT  = 8'h0c;
  localparam logic [31:0] CTRL_RESET  = 32'h00000000;

  // Message kinds on the link
  localparam logic [1:0] MSG_FIND   = 2'h0;
  localparam logic [1:0] MSG_SELECT = 2'h1;
  localparam logic [1:0] MSG_CMD    = 2'h2;

  // Status LED codes and AXI4-Lite response codes
  localparam logic [7:0] LED_OK     = 8'h00;
  localparam logic [7:0] LED_ABORT  = 8'h0e;
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [5:0] {
    NBC_IDLE   = 6'b000001,
    NBC_FINDW  = 6'b000010,
    NBC_SELW   = 6'b000100,
    NBC_CMDW   = 6'b001000,
    NBC_RUN    = 6'b010000,
    NBC_ABORT  = 6'b100000
  } nbc_state_t;
endpackage
`default_nettype wire

// File: testbench/nbc_client_chk.sv
`timescale 1ns/1ns
`default_nettype none
module nbc_client_chk (
  // Clock, reset and inputs
  input wire logic                         core_clk,
  input wire logic                         resetn,
  input wire logic                         bootStrap,
  input wire logic                         softReset,
  input wire logic [47:0]                  ownAddr,
  input wire logic [31:0]                  configWord,
  input wire logic                         rxValid,
  input wire logic [1:0]                   rxKind,
  input wire logic                         cmdDone,
  input wire logic [7:0]                   cmdResult,
  input wire logic                         txReady,
  // Outputs
  input wire logic                         cmdStart,
  input wire logic                         txValid,
  input wire logic [1:0]                   txKind,
  input wire logic                         txIsReply,
  input wire logic [47:0]                  txDstAddr,
  input wire logic [7:0]                   txVersion,
  input wire logic [7:0]                   txBufCount,
  input wire logic [15:0]                  txBufLen,
  input wire logic [47:0]                  txOwnAddr,
  input wire logic [nbc_pkg::MID_BITS-1:0] txMsgId,
  input wire logic [31:0]                  txConfig,
  input wire logic [7:0]                   txResult,
  input wire logic [7:0]                   statusLed,
  input wire logic                         runCode
);
  import nbc_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence find_req;
    txValid && !txIsReply && txKind == MSG_FIND;
  endsequence
  sequence cmd_rep;
    txValid && txIsReply && txKind == MSG_CMD;
  endsequence
  tx_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txKind) && $stable(txMsgId))
    else $error("request dropped or changed before it was taken");
  find_bcast_a: assert property (find_req |-> txDstAddr == BCAST_ADDR)
    else $error("discovery request not broadcast");
  req_fields_a: assert property (txValid && !txIsReply |-> txVersion == PROTO_VERSION
    && txBufCount == RX_BUF_COUNT && txBufLen == RX_BUF_LEN && txOwnAddr == ownAddr && txConfig == configWord)
    else $error("request fields wrong");
  strap_boot_a: assert property ($rose(resetn) && bootStrap |-> ##[1:6] find_req)
    else $error("no discovery request after reset with strap");
  abort_hold_a: assert property (statusLed == LED_ABORT && !softReset |=> statusLed == LED_ABORT)
    else $error("abort code left before reset");
  run_quiet_a: assert property (runCode && !softReset |=> runCode && !cmdStart)
    else $error("run state left or command started");
  cmd_reply_a: assert property (cmdDone |-> ##2 cmd_rep ##0 txResult == $past(cmdResult, 2))
    else $error("command reply missing or wrong result");
  cmd_start_a: assert property (cmdStart |-> $past(rxValid) && $past(rxKind) == MSG_CMD)
    else $error("command started without a command");
endmodule // nbc_client_chk
bind nbc_client nbc_client_chk nbc_client_chk_inst (.core_clk, .resetn, .bootStrap, .softReset, .ownAddr,
  .configWord, .rxValid, .rxKind, .cmdDone, .cmdResult, .txReady, .cmdStart, .txValid, .txKind, .txIsReply,
  .txDstAddr, .txVersion, .txBufCount, .txBufLen, .txOwnAddr, .txMsgId, .txConfig, .txResult, .statusLed, .runCode);
`default_nettype wire

// File: testbench/nbc_server_model.sv
`timescale 1ns/1ns
`default_nettype none
module nbc_server_model #(
  parameter logic [47:0] SRV  = 48'h020000000001,
  parameter logic [15:0] TF   = 16'h0004,
  parameter logic [15:0] TS   = 16'h0008,
  parameter int          NCMD = 3
) (
  // Clock, reset, behaviour: 0 normal, 1 silent, 2 faulty, 3 no claim replies
  input  wire logic                         core_clk,
  input  wire logic                         resetn,
  input  wire logic [1:0]                   mode,
  // Client messages
  input  wire logic                         txValid,
  output logic                              txReady,
  input  wire logic [1:0]                   txKind,
  input  wire logic                         txIsReply,
  input  wire logic [nbc_pkg::MID_BITS-1:0] txMsgId,
  // Server messages
  output logic                              rxValid,
  output logic [1:0]                        rxKind,
  output logic [47:0]                       rxSrcAddr,
  output logic [47:0]                       rxServerAddr,
  output logic [15:0]                       rxTimeout,
  output logic [nbc_pkg::MID_BITS-1:0]      rxMsgId,
  output logic                              rxRunCode
);
  import nbc_pkg::*;
  logic [1:0]   step;
  logic [127:0] lastId;
  logic [95:0]  sid;
  int           nCmd;
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      txReady <= 1'b0;
      rxValid <= 1'b0;
      step    <= 2'h0;
      nCmd    <= 0;
    end else begin
      rxValid   <= 1'b0;
      txReady   <= txValid && !txReady;
      rxMsgId   <= ~rxMsgId;
      rxSrcAddr <= ~rxSrcAddr;
      rxKind    <= ~rxKind;
      if (step != 2'h0) begin
        rxValid      <= 1'b1;
        rxKind       <= step == 2'h1 ? MSG_FIND : MSG_CMD;
        rxSrcAddr    <= step == 2'h1 ? SRV + 48'h1 : SRV;
        rxServerAddr <= step == 2'h1 ? SRV + 48'h1 : SRV;
        rxMsgId      <= step == 2'h1 ? lastId : {step == 2'h3 ? ~sid : sid, 32'(nCmd)};
        rxRunCode    <= nCmd == NCMD - 1;
        rxTimeout    <= TS;
        step         <= step == 2'h3 ? 2'h2 : 2'h0;
      end else if (txValid && txReady && mode != 2'h1) begin
        lastId       <= txMsgId;
        rxSrcAddr    <= SRV;
        rxServerAddr <= SRV;
        rxMsgId      <= txMsgId;
        rxKind       <= txKind;
        rxRunCode    <= 1'b0;
        rxTimeout    <= txKind == MSG_FIND ? TF : TS;
        if (!txIsReply && txKind == MSG_FIND) begin
          rxValid <= 1'b1;
          step    <= mode == 2'h2 ? 2'h1 : 2'h0;
        end
        if (!txIsReply && txKind == MSG_SELECT && mode != 2'h3) begin
          rxValid <= 1'b1;
          sid     <= txMsgId[127:32];
          nCmd    <= 0;
          step    <= mode == 2'h2 ? 2'h3 : 2'h2;
        end
        if (txIsReply && txKind == MSG_CMD && nCmd < NCMD - 1) begin
          nCmd <= nCmd + 1;
          step <= 2'h2;
        end
      end
    end
  end
endmodule // nbc_server_model
`default_nettype wire

// File: testbench/network_boot_client_fsm_test.sv
`timescale 1ns/1ns
`default_nettype none
module network_boot_client_fsm_test;
  import nbc_pkg::*;
  localparam logic [47:0] SRV  = 48'h02a0b0c0d0e0;
  localparam logic [15:0] TF   = 16'h0004;
  localparam logic [15:0] TS   = 16'h0008;
  localparam int          NCMD = 3;
  typedef struct packed { logic [7:0] a; logic [31:0] d; logic [1:0] r; } nbc_row_t;
  nbc_row_t rows [5] = '{'{REG_CTRL, 32'h0, AXI_OKAY}, '{REG_STATUS, 32'h1, AXI_OKAY},
    '{REG_COUNTERS, 32'h0, AXI_OKAY}, '{REG_TIMEOUT, 32'h0bb8, AXI_OKAY}, '{8'h10, 32'h0, AXI_SLVERR}};
  logic core_clk, resetn, bootStrap, softReset, cmdStart, cmdDone, txValid, txReady, txIsReply, rxValid, rxRunCode;
  logic runCode, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] mode, rxKind, txKind, s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb;
  logic [7:0] cmdResult, txVersion, txBufCount, txResult, statusLed, s_axi_awaddr, s_axi_araddr;
  logic [15:0] idRandom, rxTimeout, txBufLen, txTimeout, selTmo;
  logic [31:0] configWord, txConfig, s_axi_wdata, s_axi_rdata;
  logic [47:0] ownAddr, rxSrcAddr, rxServerAddr, txDstAddr, txOwnAddr, selDst;
  logic [MID_BITS-1:0] rxMsgId, txMsgId;
  int fail_count, cmp_count, cyc, findCnt, selCnt, startCnt, repCnt, findAt, findPrev;
  nbc_client #(.MS_CYCLES(1)) nbc_client_inst (.core_clk, .resetn, .bootStrap, .softReset, .ownAddr, .configWord,
    .idRandom, .rxValid, .rxKind, .rxSrcAddr, .rxServerAddr, .rxTimeout, .rxMsgId, .rxRunCode, .cmdStart, .cmdDone,
    .cmdResult, .txValid, .txReady, .txKind, .txIsReply, .txDstAddr, .txVersion, .txBufCount, .txBufLen, .txOwnAddr,
    .txMsgId, .txTimeout, .txConfig, .txResult, .statusLed, .runCode, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  nbc_server_model #(.SRV(SRV), .TF(TF), .TS(TS), .NCMD(NCMD)) nbc_server_model_inst (.core_clk, .resetn, .mode,
    .txValid, .txReady, .txKind, .txIsReply, .txMsgId, .rxValid, .rxKind, .rxSrcAddr, .rxServerAddr, .rxTimeout,
    .rxMsgId, .rxRunCode);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc       <= cyc + 1;
    cmdDone   <= cmdStart;
    cmdResult <= ~cmdResult;
    if (cmdStart) startCnt <= startCnt + 1;
    if (txValid && txReady && !txIsReply && txKind == MSG_FIND) begin
      findCnt  <= findCnt + 1;
      findPrev <= findAt;
      findAt   <= cyc;
    end
    if (txValid && txReady && !txIsReply && txKind == MSG_SELECT) begin
      selCnt <= selCnt + 1;
      selDst <= txDstAddr;
      selTmo <= txTimeout;
    end
    if (txValid && txReady && txIsReply && txKind == MSG_CMD) repCnt <= repCnt + 1;
  end
  task automatic stop_test;
    if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wait_for(input int what, input int lim);
    for (int n = 0; n <= lim; n++) begin
      if ((what == 0 && runCode === 1'b1) || (what == 1 && statusLed === LED_ABORT) || (what > 1 && findCnt >= what - 1))
        return;
      @(posedge core_clk);
    end
    fail_count++;
    stop_test();
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge core_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    repeat (50) begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        s_axi_bready <= 1'b0;
        check("bresp", 64'(r), 64'(s_axi_bresp));
        return;
      end
    end
    fail_count++;
    stop_test();
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    repeat (50) begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        s_axi_rready <= 1'b0;
        check("rdata", 64'(d), 64'(s_axi_rdata));
        check("rresp", 64'(r), 64'(s_axi_rresp));
        return;
      end
    end
    fail_count++;
    stop_test();
  endtask
  task automatic hw_reset(input logic strap, input logic [1:0] m);
    resetn    <= 1'b0;
    bootStrap <= strap;
    mode      <= m;
    repeat (3) @(posedge core_clk);
    findCnt  = 0;
    selCnt   = 0;
    startCnt = 0;
    repCnt   = 0;
    resetn <= 1'b1;
  endtask
  initial begin
    {resetn, softReset, bootStrap, mode, cmdDone, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {fail_count, cmp_count, cyc, findAt, findPrev} = '0;
    s_axi_wstrb = 4'hf;
    cmdResult   = 8'h5a;
    ownAddr     = 48'h02aa55aa55aa;
    configWord  = 32'h13572468;
    idRandom    = 16'h9bd1;
    hw_reset(1'b0, 2'h0);
    foreach (rows[i]) axi_rd(rows[i].a, rows[i].d, rows[i].r);
    repeat (20) @(posedge core_clk);
    check("finds", 64'h0, 64'(findCnt));
    axi_wr(REG_CTRL, 32'h1, AXI_OKAY);
    axi_wr(8'h10, 32'h1, AXI_SLVERR);
    wait_for(0, 500);
    repeat (4) @(posedge core_clk);
    check("finds", 64'h1, 64'(findCnt));
    check("claims", 64'h1, 64'(selCnt));
    check("claimDst", 64'(SRV), 64'(selDst));
    check("claimTmo", 64'(TF), 64'(selTmo));
    check("commands", 64'(NCMD), 64'(startCnt));
    check("replies", 64'(NCMD), 64'(repCnt));
    axi_rd(REG_STATUS, 32'h10, AXI_OKAY);
    axi_rd(REG_COUNTERS, 32'h101, AXI_OKAY);
    axi_rd(REG_TIMEOUT, 32'(TS), AXI_OKAY);
    axi_rd(REG_CTRL, 32'h0, AXI_OKAY);
    hw_reset(1'b1, 2'h2);
    wait_for(0, 500);
    check("claimDst", 64'(SRV), 64'(selDst));
    check("commands", 64'(NCMD), 64'(startCnt));
    hw_reset(1'b1, 2'h1);
    wait_for(2, 50);
    mode <= 2'h3;
    wait_for(3, 4000);
    check("findGap", 64'h1, 64'(findAt - findPrev >= 3000 && findAt - findPrev <= 3010));
    wait_for(1, 20000);
    check("finds", 64'd16, 64'(findCnt));
    check("claims", 64'd240, 64'(selCnt));
    axi_rd(REG_STATUS, 32'h0e20, AXI_OKAY);
    axi_rd(REG_COUNTERS, 32'h1010, AXI_OKAY);
    mode <= 2'h0;
    findCnt = 0;
    softReset <= 1'b1;
    @(posedge core_clk);
    softReset <= 1'b0;
    wait_for(0, 500);
    check("finds", 64'h1, 64'(findCnt));
    check("led", 64'(LED_OK), 64'(statusLed));
    stop_test();
  end
endmodule // network_boot_client_fsm_test
`default_nettype wire
